// *** rtl/port_block_pkg.sv ***
// constants, types and functional notes for the port register blocks
// Functional notes
// - downstream decodes one contiguous 4K register window
// - downstream 64-byte header follows type 1 layout
// - first word reads as null extended header
// - null header points onward to offset 100h
// - 64-bit private base pointer at 10h/14h
// - downstream pointer locates its subsystem register region
// - capabilities found only by walking next pointers
// - downstream capabilities sit within 100h to FFFh
// - downstream slot registers are not applicable
// - both ports carry error reporting capability
// - downstream chain lists its required capability set
// - upstream also decodes its own 4K block
// - upstream latches bits 63:12 of first access outside the downstream block
// - upstream 64-byte header follows type 0 layout
// - upstream pointer locates its subsystem register region
// - upstream plain capabilities within 040h to 0FFh
// - upstream extended capabilities within 100h to FFFh
package port_block_pkg;
	localparam int          ADDR_W      = 64;        // memory address
	localparam int          OFF_W       = 12;        // 4K block offset
	localparam int          BASE_W      = ADDR_W - OFF_W;
	// header word offsets
	localparam logic [11:0] OFF_NULL    = 12'h000;
	localparam logic [11:0] OFF_CMD     = 12'h004;
	localparam logic [11:0] OFF_CLASS   = 12'h008;
	localparam logic [11:0] OFF_HTYPE   = 12'h00c;
	localparam logic [11:0] OFF_BAR_LO  = 12'h010;
	localparam logic [11:0] OFF_BAR_HI  = 12'h014;
	localparam logic [11:0] OFF_CAP_PTR = 12'h034;
	// capability windows
	localparam logic [11:0] STD_LO      = 12'h040;
	localparam logic [11:0] STD_HI      = 12'h0ff;
	localparam logic [11:0] EXT_LO      = 12'h100;
	// fixed field values
	localparam logic [31:0] NULL_HDR    = 32'h1000_0000;
	localparam logic [7:0]  HTYPE_T1    = 8'h01;
	localparam logic [7:0]  HTYPE_T0    = 8'h00;
	localparam logic [3:0]  BAR_TYPE    = 4'h4;      // 64-bit memory
	localparam logic [59:0] BAR_RST     = 60'h0;
	localparam logic [15:0] CMD_RST     = 16'h0000;
	localparam logic [15:0] CMD_WMASK   = 16'h0146;
	localparam int          CMD_MEM_EN  = 1;
	// capability identifiers
	localparam logic [7:0]  ID_PCIE     = 8'h10;
	localparam logic [7:0]  ID_PM       = 8'h01;
	localparam logic [7:0]  ID_MSI      = 8'h05;
	localparam logic [15:0] ID_AER      = 16'h0001;
	localparam logic [15:0] ID_VC       = 16'h0002;
	localparam logic [15:0] ID_ACS      = 16'h000d;
	localparam logic [15:0] ID_MCAST    = 16'h0012;
	localparam logic [15:0] ID_DPC      = 16'h001d;
	localparam logic [15:0] ID_DVSEC    = 16'h0023;
	localparam logic [3:0]  EXT_VER     = 4'h1;
	// capability placement
	localparam logic [11:0] DN_PCIE     = 12'h380;
	localparam logic [11:0] DN_PM       = 12'h3c0;
	localparam logic [11:0] DN_MSI      = 12'h3e0;
	localparam logic [7:0]  DN_CAP_PTR  = 8'he0;     // 380h in dwords
	localparam logic [7:0]  UP_CAP_PTR  = 8'h40;     // byte offset
	localparam logic [11:0] SLOT_CAP    = 12'h014;
	localparam logic [11:0] SLOT_CTL    = 12'h018;
	localparam logic [11:0] SLOT_CAP2   = 12'h034;
	localparam logic [11:0] SLOT_CTL2   = 12'h038;
	// one memory access from the link
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic [3:0]        be;
	} mem_req_t;
	// one answer to it
	typedef struct packed {
		logic        hit;
		logic [31:0] rdata;
	} mem_rsp_t;
endpackage

// *** rtl/cap_chain_rom.sv ***
// fixed capability headers of one port block
`timescale 1ns/1ps
`default_nettype none
module cap_chain_rom #(
	parameter bit          UPSTREAM = 1'b0,
	parameter logic [15:0] DV_VENDOR = 16'h1234  // arbitrary value
) (
	input  wire logic [11:2] i_off,
	output logic      [31:0] o_data
);
	import port_block_pkg::*;

	// extended header word
	function automatic logic [31:0] ext(input logic [15:0] id,
		input logic [11:0] nxt);
		ext = {nxt, EXT_VER, id};
	endfunction

	// header lookup, anything else reads zero
	always_comb begin
		o_data = 32'h0;
		if (UPSTREAM) begin
			unique case ({i_off, 2'b00})
				12'h040: o_data = {16'h0052, 8'h00, ID_PCIE};
				12'h100: o_data = ext(ID_AER, 12'h180);
				12'h180: o_data = ext(ID_MCAST, 12'h200);
				12'h200: o_data = ext(ID_VC, 12'h280);
				12'h280: o_data = ext(ID_DVSEC, 12'h000);
				12'h284: o_data = {12'h010, 4'h0, DV_VENDOR};
				12'h288: o_data = 32'h0000_0007;
				default: o_data = 32'h0;
			endcase
		end else begin
			unique case ({i_off, 2'b00})
				12'h100: o_data = ext(ID_AER, 12'h180);
				12'h180: o_data = ext(ID_ACS, 12'h200);
				12'h200: o_data = ext(ID_MCAST, 12'h280);
				12'h280: o_data = ext(ID_DPC, 12'h300);
				12'h300: o_data = ext(ID_DVSEC, 12'h000);
				12'h304: o_data = {12'h010, 4'h0, DV_VENDOR};
				12'h308: o_data = 32'h0000_0007;
				// plain list, next bytes in dwords
				DN_PCIE: o_data = {16'h0042, 8'hf0, ID_PCIE};
				DN_PM:   o_data = {16'h0003, 8'hf8, ID_PM};
				DN_MSI:  o_data = {16'h0080, 8'h00, ID_MSI};
				default: o_data = 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** rtl/block_base_capture.sv ***
// upstream block base, caught from first access after link start that misses the downstream block
`timescale 1ns/1ps
`default_nettype none
module block_base_capture (
	input  wire logic                               i_mclk,
	input  wire logic                               i_resetn,
	input  wire logic                               i_link_init,
	input  wire logic                               i_req_valid,
	input  wire logic [port_block_pkg::BASE_W-1:0]  i_req_base,
	input  wire logic                               i_other_hit,
	output logic                                    o_armed,
	output logic                                    o_valid,
	output logic      [port_block_pkg::BASE_W-1:0]  o_base
);
	import port_block_pkg::*;

	// whole state of the catcher
	typedef struct packed {
		logic              armed;  // waiting for first access
		logic              valid;  // base held
		logic [BASE_W-1:0] base;   // address bits 63:12
	} cap_state_t;

	localparam cap_state_t CAP_RST = '{1'b0, 1'b0, '0};

	cap_state_t c_q, c_d;

	// arm on link start, latch once, then hold
	always_comb begin
		c_d = c_q;
		if (i_link_init) begin
			c_d.armed = 1'b1;
			c_d.valid = 1'b0;
		end else if (c_q.armed && i_req_valid && !i_other_hit) begin
			c_d.base  = i_req_base;
			c_d.valid = 1'b1;
			c_d.armed = 1'b0;
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			c_q <= CAP_RST;
		end else begin
			c_q <= c_d;
		end
	end

	assign o_armed = c_q.armed;
	assign o_valid = c_q.valid;
	assign o_base  = c_q.base;
endmodule
`default_nettype wire

// *** rtl/port_register_block.sv ***
// downstream and upstream port register blocks on one access port
`timescale 1ns/1ps
`default_nettype none
module port_register_block #(
	parameter int          DATA_W     = 32,
	parameter logic [7:0]  REV_ID     = 8'h01,
	parameter logic [23:0] CLASS_CODE = 24'h060400,
	parameter logic [15:0] DV_VENDOR  = 16'h1234  // arbitrary value
) (
	input  wire logic                              i_mclk,
	input  wire logic                              i_resetn,
	input  wire logic                              i_link_init,
	input  wire logic [port_block_pkg::BASE_W-1:0] i_dn_block_base,
	input  wire logic                              i_req_valid,
	input  wire port_block_pkg::mem_req_t          i_req,
	output logic                                   o_rsp_valid,
	output port_block_pkg::mem_rsp_t               o_rsp,
	output logic      [63:0]                       o_dn_priv_base,
	output logic      [63:0]                       o_up_priv_base,
	output logic                                   o_dn_mem_en,
	output logic                                   o_up_mem_en,
	output logic      [port_block_pkg::BASE_W-1:0] o_up_block_base,
	output logic                                   o_up_base_valid
);
	import port_block_pkg::*;

	// refuse widths the decode cannot serve
	if (DATA_W != 32) begin : g_bad_width
		$error("only 32-bit data is supported");
	end

	// whole state of the block
	typedef struct packed {
		logic        rsp_valid;  // answer strobe
		mem_rsp_t    rsp;        // answer word
		logic [59:0] dn_bar;     // downstream base bits 63:4
		logic [59:0] up_bar;     // upstream base bits 63:4
		logic [15:0] dn_cmd;     // downstream command
		logic [15:0] up_cmd;     // upstream command
	} state_t;

	localparam state_t S_RST = '{
		rsp_valid: 1'b0,
		rsp:       '0,
		dn_bar:    BAR_RST,
		up_bar:    BAR_RST,
		dn_cmd:    CMD_RST,
		up_cmd:    CMD_RST
	};

	state_t s_q, s_d;

	// decode signals
	logic [11:0]       off;        // byte offset in block
	logic [BASE_W-1:0] req_base;   // address bits 63:12
	logic              dn_hit;     // access in downstream block
	logic              up_hit;     // access in upstream block
	logic              up_armed;   // upstream waits for base
	logic              up_valid;   // upstream base held
	logic [BASE_W-1:0] up_base;    // upstream block base
	logic [31:0]       rom_word [2]; // capability lookups
	logic              slot_zero;  // slot register window
	logic [31:0]       rd_word;    // read data chosen

	assign off      = {i_req.addr[11:2], 2'b00};
	assign req_base = i_req.addr[ADDR_W-1:OFF_W];

	// downstream window at its relocatable base
	assign dn_hit = i_req_valid &&
		(req_base == i_dn_block_base);

	// upstream window, the first access defines it
	assign up_hit = i_req_valid && !dn_hit &&
		(up_armed || (up_valid && req_base == up_base));

	// base catcher for the upstream block
	block_base_capture u_capture (
		.i_mclk      (i_mclk),
		.i_resetn    (i_resetn),
		.i_link_init (i_link_init),
		.i_req_valid (i_req_valid),
		.i_req_base  (req_base),
		.i_other_hit (dn_hit),
		.o_armed     (up_armed),
		.o_valid     (up_valid),
		.o_base      (up_base)
	);

	// one header lookup per port, index 1 is upstream
	for (genvar p = 0; p < 2; p++) begin : g_rom
		cap_chain_rom #(
			.UPSTREAM  (p == 1),
			.DV_VENDOR (DV_VENDOR)
		) u_rom (
			.i_off  (i_req.addr[11:2]),
			.o_data (rom_word[p])
		);
	end

	// merge written bytes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// header and capability read of one block
	function automatic logic [31:0] blk_read(input logic up,
		input logic [11:0] o, input logic [59:0] bar,
		input logic [15:0] cmd, input logic [31:0] rom);
		logic [31:0] v;
		v = 32'h0;
		case (o)
			// null extended header opens the chain
			OFF_NULL: v = NULL_HDR;
			// command word, status reads zero
			OFF_CMD: v = {16'h0000, cmd};
			// class and revision
			OFF_CLASS: v = {CLASS_CODE, REV_ID};
			// header type tells type 0 from type 1
			OFF_HTYPE: v = {8'h00,
				up ? HTYPE_T0 : HTYPE_T1, 16'h0000};
			// private base pointer, low word
			OFF_BAR_LO: v = {bar[27:0], BAR_TYPE};
			// private base pointer, high word
			OFF_BAR_HI: v = bar[59:28];
			// plain capability list head
			OFF_CAP_PTR: v = {24'h0,
				up ? UP_CAP_PTR : DN_CAP_PTR};
			default: begin
				// capability area, ranges differ per side
				if (o >= EXT_LO) begin
					v = rom;
				end else if (up && o >= STD_LO) begin
					v = rom;
				end else begin
					v = 32'h0;
				end
			end
		endcase
		return v;
	endfunction

	// slot registers of the downstream express capability
	always_comb begin
		slot_zero = 1'b0;
		if (off == DN_PCIE + SLOT_CAP || off == DN_PCIE + SLOT_CTL ||
			off == DN_PCIE + SLOT_CAP2 ||
			off == DN_PCIE + SLOT_CTL2) begin
			slot_zero = 1'b1;
		end
	end

	// pick the read word of whichever block is hit
	always_comb begin
		rd_word = 32'h0;
		if (dn_hit) begin
			rd_word = blk_read(1'b0, off, s_q.dn_bar, s_q.dn_cmd,
				rom_word[0]);
			if (slot_zero) begin
				rd_word = 32'h0;
			end
		end else if (up_hit) begin
			rd_word = blk_read(1'b1, off, s_q.up_bar, s_q.up_cmd,
				rom_word[1]);
		end
	end

	// next state: answers and register writes
	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		s_d = s_q;
		// one answer per access, one cycle later
		s_d.rsp_valid = i_req_valid;
		s_d.rsp.hit   = dn_hit || up_hit;
		s_d.rsp.rdata = i_req.wr ? 32'h0 : rd_word;
		if (i_req.wr && dn_hit) begin
			// downstream writable words only
			unique case (off)
				OFF_CMD: begin
					m = merge({16'h0, s_q.dn_cmd}, i_req.wdata, i_req.be);
					s_d.dn_cmd = m[15:0] & CMD_WMASK;
				end
				OFF_BAR_LO: begin
					m = merge({s_q.dn_bar[27:0], BAR_TYPE},
						i_req.wdata, i_req.be);
					s_d.dn_bar[27:0] = m[31:4];
				end
				OFF_BAR_HI: begin
					m = merge(s_q.dn_bar[59:28], i_req.wdata, i_req.be);
					s_d.dn_bar[59:28] = m;
				end
				default: begin
					// read-only or unmapped, write dropped
					m = 32'h0;
				end
			endcase
		end else if (i_req.wr && up_hit) begin
			// upstream writable words only
			unique case (off)
				OFF_CMD: begin
					m = merge({16'h0, s_q.up_cmd}, i_req.wdata, i_req.be);
					s_d.up_cmd = m[15:0] & CMD_WMASK;
				end
				OFF_BAR_LO: begin
					m = merge({s_q.up_bar[27:0], BAR_TYPE},
						i_req.wdata, i_req.be);
					s_d.up_bar[27:0] = m[31:4];
				end
				OFF_BAR_HI: begin
					m = merge(s_q.up_bar[59:28], i_req.wdata, i_req.be);
					s_d.up_bar[59:28] = m;
				end
				default: begin
					// read-only or unmapped, write dropped
					m = 32'h0;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q <= S_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs, all from flops
	assign o_rsp_valid     = s_q.rsp_valid;
	assign o_rsp           = s_q.rsp;
	assign o_dn_priv_base  = {s_q.dn_bar, 4'h0};
	assign o_up_priv_base  = {s_q.up_bar, 4'h0};
	assign o_dn_mem_en     = s_q.dn_cmd[CMD_MEM_EN];
	assign o_up_mem_en     = s_q.up_cmd[CMD_MEM_EN];
	assign o_up_block_base = up_base;
	assign o_up_base_valid = up_valid;

	// reads of either block that hit
	logic rd_hit;
	assign rd_hit = i_req_valid && !i_req.wr && (dn_hit || up_hit);

	AST_NULL_HDR:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		rd_hit && off == OFF_NULL |=> o_rsp.rdata == 32'h1000_0000)
		else $error("null header word wrong");

	AST_DN_TYPE1:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		dn_hit && !i_req.wr && off == OFF_HTYPE
		|=> o_rsp.rdata[23:16] == 8'h01)
		else $error("downstream header type not type 1");

	AST_UP_TYPE0:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		up_hit && !i_req.wr && off == OFF_HTYPE
		|=> o_rsp.hit && o_rsp.rdata[23:16] == 8'h00)
		else $error("upstream header type not type 0");

	AST_BAR_HI_WRITE:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		dn_hit && i_req.wr && i_req.be == 4'hf && off == OFF_BAR_HI
		|=> o_dn_priv_base[63:32] == $past(i_req.wdata))
		else $error("downstream base pointer high word lost");

	AST_UP_CATCH:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		up_armed && i_req_valid && !dn_hit && !i_link_init
		|=> o_up_base_valid && o_up_block_base == $past(req_base))
		else $error("upstream base not caught");

	AST_UP_ONCE:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_up_base_valid && !i_link_init |=> $stable(o_up_block_base))
		else $error("upstream base moved without link start");

	AST_MISS_ZERO:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		i_req_valid && !dn_hit && !up_hit
		|=> o_rsp_valid && !o_rsp.hit && o_rsp.rdata == 32'h0)
		else $error("miss answered with data");

	AST_DN_LOW_EMPTY:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		dn_hit && !i_req.wr && off >= 12'h040 && off < 12'h100
		|=> o_rsp.rdata == 32'h0)
		else $error("downstream capability below 100h");

	AST_UP_STD_CAP:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		up_hit && !i_req.wr && off == 12'h040
		|=> o_rsp.rdata[7:0] == 8'h10)
		else $error("upstream express capability missing");

	AST_AER_FIRST:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		rd_hit && off == 12'h100 |=> o_rsp.rdata[15:0] == 16'h0001)
		else $error("error reporting not first extended");

	AST_SLOT_ZERO:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		dn_hit && !i_req.wr && off == 12'h394 ##1 o_rsp_valid
		|-> o_rsp.rdata == 32'h0)
		else $error("slot register not zero");

	AST_ANSWER_ONE:
	assert property (@(posedge i_mclk) disable iff (!i_resetn)
		i_req_valid |=> o_rsp_valid ##1 (o_rsp_valid == $past(i_req_valid)))
		else $error("answer strobe out of step");
endmodule
`default_nettype wire

// *** tb/host_access_model.sv ***
// host side model issuing single memory accesses to the register blocks
`timescale 1ns/1ps
`default_nettype none
module host_access_model (
	input  wire logic                     i_mclk,
	output var  logic                     o_req_valid,
	output var  port_block_pkg::mem_req_t o_req,
	input  wire logic                     i_rsp_valid,
	input  wire port_block_pkg::mem_rsp_t i_rsp
);
	import port_block_pkg::*;
	// idle bus until the first access
	initial begin
		o_req_valid = 1'b0;
		o_req       = '0;
	end
	// one access: optional stall, request held over one edge, answer after
	task automatic access(input logic wr, input logic [63:0] addr,
		input logic [31:0] wd, input logic [3:0] be, input int gap,
		output logic got, output logic hit, output logic [31:0] rd);
		repeat (gap) @(posedge i_mclk);
		@(posedge i_mclk);
		#1;
		o_req_valid = 1'b1;
		o_req       = '{wr: wr, addr: addr, wdata: wd, be: be};
		@(posedge i_mclk);
		#1;
		got         = i_rsp_valid;
		hit         = i_rsp.hit;
		rd          = i_rsp.rdata;
		o_req_valid = 1'b0;
		// released bus carries the inverted last request
		o_req       = ~o_req;
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the port register blocks
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import port_block_pkg::*;
	logic        i_mclk;                   // bench clock
	logic        i_resetn;                 // active low reset
	logic        link_init;                // link start pulse
	logic [51:0] dn_base;                  // downstream block base
	logic        req_valid;                // access strobe
	mem_req_t    req;                      // access
	logic        rsp_valid;                // answer strobe
	mem_rsp_t    rsp;                      // answer
	logic [63:0] dn_priv, up_priv;         // private bases
	logic        dn_mem, up_mem;           // memory enables
	logic [51:0] up_blk;                   // caught upstream base
	logic        up_ok;                    // upstream base held
	int          bad_count, total_checks;  // tallies
	logic [51:0] base [2];                 // model block bases
	logic [63:0] ptr [2];                  // model private pointers
	logic [15:0] cmd [2];                  // model command words
	int          dn_q[$], up_q[$];         // expected extended chains
	logic [11:0] model_off [8] = '{12'h000, 12'h004, 12'h008, 12'h00c,
		12'h010, 12'h014, 12'h034, 12'h018};     // header words
	logic [11:0] slot_off [4] = '{SLOT_CAP, SLOT_CTL, SLOT_CAP2, SLOT_CTL2};
	logic [11:0] plain_off [3] = '{DN_PCIE, DN_PM, DN_MSI};
	logic [7:0]  plain_id [3] = '{ID_PCIE, ID_PM, ID_MSI};
	port_register_block i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_link_init(link_init), .i_dn_block_base(dn_base),
		.i_req_valid(req_valid), .i_req(req), .o_rsp_valid(rsp_valid),
		.o_rsp(rsp), .o_dn_priv_base(dn_priv), .o_up_priv_base(up_priv),
		.o_dn_mem_en(dn_mem), .o_up_mem_en(up_mem),
		.o_up_block_base(up_blk), .o_up_base_valid(up_ok));
	host_access_model i_host (.i_mclk(i_mclk), .o_req_valid(req_valid),
		.o_req(req), .i_rsp_valid(rsp_valid), .i_rsp(rsp));
	// free running clock
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	// compare and tally
	task automatic check(input logic [63:0] seen, input logic [63:0] exp,
		input string msg);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// byte-lane merge of a write
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd,
		logic [3:0] be);
		for (int i = 0; i < 4; i++) if (be[i]) old[8*i+:8] = wd[8*i+:8];
		return old;
	endfunction
	// model read value of a header word
	function automatic logic [31:0] model_rd(int p, logic [11:0] off);
		case (off)
			12'h000: return NULL_HDR;
			12'h004: return {16'h0000, cmd[p]};
			12'h008: return 32'h0604_0001;
			12'h00c: return {8'h00, (p != 0) ? HTYPE_T0 : HTYPE_T1, 16'h0000};
			12'h010: return {ptr[p][31:4], BAR_TYPE};
			12'h014: return ptr[p][63:32];
			12'h034: return {24'h0, (p != 0) ? UP_CAP_PTR : DN_CAP_PTR};
			default: return 32'h0;
		endcase
	endfunction
	// access at an address, model updated on writes
	task automatic op(input logic wr, input logic [63:0] a,
		input logic [31:0] wd, input logic [3:0] be,
		output logic hit, output logic [31:0] rd);
		logic        got;
		logic [31:0] t;
		int          p;
		i_host.access(wr, a, wd, be, $urandom_range(2), got, hit, rd);
		check(got, 1'b1, "answer strobe");
		p = (a[63:12] == base[1]) ? 1 : 0;
		if (wr && a[11:0] == 12'h004) begin
			t = merge({16'h0, cmd[p]}, wd, be);
			cmd[p] = t[15:0] & CMD_WMASK;
		end
		if (wr && a[11:0] == 12'h010) begin
			t = merge(ptr[p][31:0], wd, be);
			ptr[p][31:0] = {t[31:4], 4'h0};
		end
		if (wr && a[11:0] == 12'h014) ptr[p][63:32] = merge(ptr[p][63:32], wd, be);
	endtask
	// read one word of a block and compare with a value
	task automatic rd_chk(input int p, input logic [11:0] off,
		input logic [31:0] exp, input string msg);
		logic        hit;
		logic [31:0] rd;
		op(1'b0, {base[p], off}, 32'h0, 4'hf, hit, rd);
		check(hit, 1'b1, msg);
		check(rd, exp, msg);
	endtask
	// main sequence
	initial begin
		logic        hit;
		logic [31:0] rd;
		logic [11:0] off;
		logic [63:0] t64;
		int          ids[$];
		void'($urandom(32'h1230be96));
		t64 = {$urandom, $urandom};
		base[0] = {1'b0, t64[50:0]};
		base[1] = base[0] + 52'h1;
		dn_base = base[0];
		ptr = '{64'h0, 64'h0};
		cmd = '{16'h0, 16'h0};
		dn_q = '{ID_AER, ID_ACS, ID_MCAST, ID_DPC, ID_DVSEC};
		up_q = '{ID_AER, ID_MCAST, ID_VC, ID_DVSEC};
		link_init = 1'b0;
		i_resetn = 1'b0;
		repeat (10) @(posedge i_mclk);
		#1;
		i_resetn = 1'b1;
		check(up_ok, 1'b0, "base held at reset");
		op(1'b0, {base[1], 12'h000}, 32'h0, 4'hf, hit, rd);
		check({hit, rd}, 33'h0, "upstream before start");
		$display("test reset done");
		@(posedge i_mclk);
		#1;
		link_init = 1'b1;
		@(posedge i_mclk);
		#1;
		link_init = 1'b0;
		rd_chk(0, 12'h000, NULL_HDR, "down hit not caught");
		check(up_ok, 1'b0, "down access caught");
		rd_chk(1, 12'h000, NULL_HDR, "first upstream access");
		check(up_ok, 1'b1, "base valid");
		check(up_blk, base[1], "caught base");
		op(1'b0, {base[0] + 52'h5, 12'h000}, 32'h0, 4'hf, hit, rd);
		check({hit, rd}, 33'h0, "outside both blocks");
		check(up_blk, base[1], "base moved");
		$display("test capture done");
		for (int p = 0; p < 2; p++) begin
			op(1'b1, {base[p], 12'h010}, $urandom, 4'hf, hit, rd);
			op(1'b1, {base[p], 12'h014}, $urandom, 4'hf, hit, rd);
			op(1'b1, {base[p], 12'h014}, $urandom, 4'b0010, hit, rd);
			op(1'b1, {base[p], 12'h004}, 32'hffff_ffff, 4'hf, hit, rd);
			op(1'b1, {base[p], 12'h000}, 32'hffff_ffff, 4'hf, hit, rd);
			foreach (model_off[i]) begin
				rd_chk(p, model_off[i], model_rd(p, model_off[i]), "header");
			end
			t64 = (p != 0) ? up_priv : dn_priv;
			check(t64, ptr[p], "private base");
			check((p != 0) ? up_mem : dn_mem, cmd[p][CMD_MEM_EN], "mem en");
		end
		$display("test header done");
		for (int p = 0; p < 2; p++) begin
			ids = (p != 0) ? up_q : dn_q;
			off = EXT_LO;
			foreach (ids[k]) begin
				op(1'b0, {base[p], off}, 32'h0, 4'hf, hit, rd);
				check(rd[15:0], ids[k], "ext id");
				off = rd[31:20];
				if (k == ids.size() - 1) check(off, 12'h0, "chain end");
				else check(off >= EXT_LO, 1'b1, "ext range");
			end
		end
		rd_chk(1, 12'h040, {16'h0052, 8'h00, ID_PCIE}, "up pcie");
		$display("test chains done");
		foreach (slot_off[i]) begin
			op(1'b1, {base[0], DN_PCIE + slot_off[i]}, 32'hffff_ffff, 4'hf,
				hit, rd);
			rd_chk(0, DN_PCIE + slot_off[i], 32'h0, "slot reg");
		end
		op(1'b1, {base[0], 12'h800}, 32'hffff_ffff, 4'hf, hit, rd);
		check(rd, 32'h0, "write answer data");
		rd_chk(0, 12'h800, 32'h0, "unmapped");
		for (int i = 0; i < 3; i++) begin
			op(1'b0, {base[0], plain_off[i]}, 32'h0, 4'hf, hit, rd);
			check(rd[7:0], plain_id[i], "plain id");
			check(rd[15:8], (i < 2) ? plain_off[i+1][9:2] : 8'h0, "next");
		end
		$display("test capabilities done");
		complete_run();
	end
	// cut a hang short
	initial begin
		#(20 * 20000);
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
